// [design/mrs_pkg.sv]
// Package: constants and types for the reset source controller
package mrs_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_PIN_FUNC = 4'h0;
   localparam logic [3:0] ADDR_FLAGS = 4'h4;
   localparam logic [3:0] ADDR_THRESH = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hc;

   // ----------------------------------------------------------------
   // Codes and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PIN_FUNC_IO = 8'h55;
   localparam logic [7:0] PIN_FUNC_RESET = 8'haa;
   localparam logic [7:0] PIN_FUNC_POR = 8'h55;
   localparam logic [7:0] THR_CODE_0 = 8'h55;
   localparam logic [7:0] THR_CODE_1 = 8'h33;
   localparam logic [7:0] THR_CODE_2 = 8'h99;
   localparam logic [7:0] THR_CODE_3 = 8'haa;
   localparam logic [7:0] THR_POR = 8'h55;
   localparam logic [3:0] FLAGS_POR = 4'h0;

   // ----------------------------------------------------------------
   // Flag bit positions
   // ----------------------------------------------------------------
   localparam int FLAG_CTRL_CODE = 3;
   localparam int FLAG_UNDERVOLT = 2;
   localparam int FLAG_THR_CODE = 1;
   localparam int FLAG_WDT_CODE = 0;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int SOFT_RESET_DELAY_NS = 1000;
   localparam int PIN_RESET_DELAY_NS = 16000;
   localparam int UNDERVOLT_FILTER_NS = 120000;
   localparam int SOFT_RESET_CYC = (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PIN_RESET_CYC = (PIN_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UNDERVOLT_FILT_CYC =
      (UNDERVOLT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_SOFT = 4'b0010,
      ST_HOLD = 4'b0100,
      ST_DELAY = 4'b1000
   } mrs_state_t;
endpackage : mrs_pkg

// [design/mrs_persist_filter.sv]
// Persistence filter: flags a level held longer than a cycle count
`timescale 1ns/100ps
module mrs_persist_filter #(
   parameter int CNT_W = 16,
   parameter int FILT_CYC = 3000
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_level,
   output logic o_hit
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic nxt_hit;
   logic reached;

   // Saturate so a long dip never wraps back into the ignore window
   assign reached = (cnt_ff == CNT_W'(FILT_CYC));
   assign nxt_cnt = !i_level ? '0 : (reached ? cnt_ff : cnt_ff + 1'b1);
   assign nxt_hit = i_level && reached;

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_ff <= '0;
         o_hit <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         o_hit <= nxt_hit;
      end
   end
endmodule : mrs_persist_filter

// [design/mrs_reset_ctrl.sv]
// Reset sequencer and reset source flag registers
//
// Behaviour
// - Power-on holds the core reset so the program counter starts at zero.
// - Power-on raises port preset so port registers load all ones.
// - Reset pin low, when selected, resets the core to address zero.
// - After pin release wait the pin reset delay; hold while pin is low.
// - Pin function code 0x55 selects plain I/O, 0xaa selects reset pin.
// - Any other pin function code resets the device after the soft delay.
// - Pin function register powers up as 0x55.
// - Invalid pin function code reset sets flag bit 3.
// - Control code flag is sticky; only a software zero write clears it.
// - With reset pin function selected, other shared functions are disabled.
// - Flag register bits 7 to 4 always read zero.
// - Undervolt reset on except in power-down; low supply resets and sets undervolt flag.
// - Undervolt reset acts only when low supply outlasts the filter time.
// - Undefined threshold code resets after soft delay and sets its flag.
// - Threshold register powers up as 0x55.
// - Undervolt reset is disabled during power-down.
// - Watchdog overflow resets the device.
// - Four threshold codes pick one level each; others force a reset.
// - Threshold code reset restores 0x55; undervolt reset keeps contents.
// - Undervolt and threshold flags are sticky; only zero writes clear.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module mrs_reset_ctrl #(
   parameter int CNT_W = mrs_pkg::CNT_W,
   parameter int SOFT_CYC = mrs_pkg::SOFT_RESET_CYC,
   parameter int PIN_CYC = mrs_pkg::PIN_RESET_CYC,
   parameter int FILT_CYC = mrs_pkg::UNDERVOLT_FILT_CYC
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_ext_reset_pin_n,
   input wire logic [3:0] i_supply_below,
   input wire logic i_supply_above_floor,
   input wire logic i_power_down,
   input wire logic i_wdt_overflow,
   input wire logic i_wdt_code_fault,
   output logic o_core_reset,
   output logic o_port_preset,
   output logic o_shared_fn_disable,
   output logic o_undervolt_en
);
   // ----------------------------------------------------------------
   // Code decoders
   // ----------------------------------------------------------------
   function automatic logic thr_valid(input logic [7:0] code);
      thr_valid = (code == mrs_pkg::THR_CODE_0) || (code == mrs_pkg::THR_CODE_1) ||
                  (code == mrs_pkg::THR_CODE_2) || (code == mrs_pkg::THR_CODE_3);
   endfunction : thr_valid

   function automatic logic [1:0] thr_index(input logic [7:0] code);
      logic [1:0] idx;
      idx = 2'd0;
      if (code == mrs_pkg::THR_CODE_1) idx = 2'd1;
      if (code == mrs_pkg::THR_CODE_2) idx = 2'd2;
      if (code == mrs_pkg::THR_CODE_3) idx = 2'd3;
      thr_index = idx;
   endfunction : thr_index

   function automatic logic pin_func_valid(input logic [7:0] code);
      pin_func_valid = (code == mrs_pkg::PIN_FUNC_IO) || (code == mrs_pkg::PIN_FUNC_RESET);
   endfunction : pin_func_valid

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   mrs_pkg::mrs_state_t state_ff;
   mrs_pkg::mrs_state_t nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic por_ff;
   logic nxt_por;
   logic [7:0] pin_func_ff;
   logic [7:0] nxt_pin_func;
   logic [7:0] thr_ff;
   logic [7:0] nxt_thr;
   logic [3:0] flags_ff;
   logic [3:0] nxt_flags;
   logic [7:0] nxt_rdata;
   logic nxt_core_reset;

   // ----------------------------------------------------------------
   // Event decoding
   // ----------------------------------------------------------------
   logic wr_pin_func;
   logic wr_flags;
   logic wr_thr;
   logic pin_sel;
   logic pin_low;
   logic pin_func_bad;
   logic thr_bad;
   logic soft_bad;
   logic lv_en;
   logic lv_low;
   logic lv_hit;
   logic hard_evt;
   logic soft_done;
   logic delay_done;
   logic fire;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic [7:0] rd_mux;

   assign wr_pin_func = i_wr && (i_addr == mrs_pkg::ADDR_PIN_FUNC);
   assign wr_flags = i_wr && (i_addr == mrs_pkg::ADDR_FLAGS);
   assign wr_thr = i_wr && (i_addr == mrs_pkg::ADDR_THRESH);

   assign pin_sel = (pin_func_ff == mrs_pkg::PIN_FUNC_RESET);
   assign pin_low = pin_sel && !i_ext_reset_pin_n;
   assign pin_func_bad = !pin_func_valid(pin_func_ff);
   assign thr_bad = !thr_valid(thr_ff);
   assign soft_bad = pin_func_bad || thr_bad || i_wdt_code_fault;

   // Comparator outputs are ignored in power-down so no dip can be counted
   assign lv_en = !i_power_down;
   assign lv_low = lv_en && i_supply_above_floor && i_supply_below[thr_index(thr_ff)];

   mrs_persist_filter #(
      .CNT_W(CNT_W),
      .FILT_CYC(FILT_CYC)
   ) u_lv_filter (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_level(lv_low),
      .o_hit(lv_hit)
   );

   assign hard_evt = pin_low || lv_hit;
   assign soft_done = (cnt_ff == CNT_W'(SOFT_CYC - 1));
   assign delay_done = (cnt_ff == CNT_W'(PIN_CYC - 1));
   assign fire = (state_ff == mrs_pkg::ST_SOFT) && !hard_evt && !i_wdt_overflow &&
                 soft_bad && soft_done;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // A code fault only arms the soft delay; a good code written back
   // before it expires cancels the pending reset.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         mrs_pkg::ST_RUN: begin
            if (hard_evt) nxt_state = mrs_pkg::ST_HOLD;
            else if (i_wdt_overflow) nxt_state = mrs_pkg::ST_DELAY;
            else if (soft_bad) nxt_state = mrs_pkg::ST_SOFT;
         end
         mrs_pkg::ST_SOFT: begin
            if (hard_evt) nxt_state = mrs_pkg::ST_HOLD;
            else if (i_wdt_overflow) nxt_state = mrs_pkg::ST_DELAY;
            else if (!soft_bad) nxt_state = mrs_pkg::ST_RUN;
            else if (soft_done) nxt_state = mrs_pkg::ST_DELAY;
         end
         mrs_pkg::ST_HOLD: begin
            if (!(pin_low || lv_low)) nxt_state = mrs_pkg::ST_DELAY;
         end
         mrs_pkg::ST_DELAY: begin
            if (hard_evt) nxt_state = mrs_pkg::ST_HOLD;
            else if (delay_done) nxt_state = mrs_pkg::ST_RUN;
         end
      endcase
   end

   assign nxt_cnt = ((nxt_state != state_ff) || (state_ff == mrs_pkg::ST_RUN) ||
                     (state_ff == mrs_pkg::ST_HOLD)) ? '0 : cnt_ff + 1'b1;
   assign nxt_core_reset = (nxt_state == mrs_pkg::ST_HOLD) ||
                           (nxt_state == mrs_pkg::ST_DELAY);
   assign nxt_por = por_ff && (nxt_state != mrs_pkg::ST_RUN);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Restoring the pin function code on its own fault reset keeps the
   // device from looping through soft resets forever.
   assign nxt_pin_func = (fire && pin_func_bad) ? mrs_pkg::PIN_FUNC_POR :
                         wr_pin_func ? i_wdata : pin_func_ff;
   assign nxt_thr = (fire && thr_bad) ? mrs_pkg::THR_POR :
                    wr_thr ? i_wdata : thr_ff;

   assign flag_set[mrs_pkg::FLAG_CTRL_CODE] = fire && pin_func_bad;
   assign flag_set[mrs_pkg::FLAG_UNDERVOLT] = lv_hit;
   assign flag_set[mrs_pkg::FLAG_THR_CODE] = fire && thr_bad;
   assign flag_set[mrs_pkg::FLAG_WDT_CODE] = fire && i_wdt_code_fault;
   assign flag_clr = wr_flags ? ~i_wdata[3:0] : 4'h0;
   // Set wins over a clear in the same cycle
   assign nxt_flags = flag_set | (flags_ff & ~flag_clr);

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   assign rd_mux = (i_addr == mrs_pkg::ADDR_PIN_FUNC) ? pin_func_ff :
                   (i_addr == mrs_pkg::ADDR_FLAGS) ? {4'h0, flags_ff} :
                   (i_addr == mrs_pkg::ADDR_THRESH) ? thr_ff :
                   (i_addr == mrs_pkg::ADDR_STATUS) ? {por_ff, 3'h0, state_ff} :
                   8'h00;
   assign nxt_rdata = i_rd ? rd_mux : 8'h00;

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_ff <= mrs_pkg::ST_DELAY;
         cnt_ff <= '0;
         por_ff <= 1'b1;
         o_core_reset <= 1'b1;
         o_port_preset <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         por_ff <= nxt_por;
         o_core_reset <= nxt_core_reset;
         o_port_preset <= nxt_por;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_func_ff <= mrs_pkg::PIN_FUNC_POR;
         thr_ff <= mrs_pkg::THR_POR;
         flags_ff <= mrs_pkg::FLAGS_POR;
         o_rdata <= 8'h00;
         o_shared_fn_disable <= 1'b0;
         o_undervolt_en <= 1'b1;
      end else begin
         pin_func_ff <= nxt_pin_func;
         thr_ff <= nxt_thr;
         flags_ff <= nxt_flags;
         o_rdata <= nxt_rdata;
         o_shared_fn_disable <= (nxt_pin_func == mrs_pkg::PIN_FUNC_RESET);
         o_undervolt_en <= lv_en;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_soft_fire;
      fire && pin_func_bad;
   endsequence

   sequence s_reset_taken;
      o_core_reset && (state_ff == mrs_pkg::ST_DELAY);
   endsequence

   property p_run_no_reset;
      (state_ff == mrs_pkg::ST_RUN) |-> !o_core_reset && !o_port_preset;
   endproperty
   a_run_no_reset: assert property (p_run_no_reset)
      else $error("core reset active while running");

   property p_pin_hold;
      pin_low |=> o_core_reset && (state_ff == mrs_pkg::ST_HOLD);
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("reset pin low did not hold the core");

   // Only a release out of the delay is timed; a cancelled code fault
   // returns from the soft wait with any count
   property p_pin_delay;
      $rose(state_ff == mrs_pkg::ST_RUN) && $past(state_ff == mrs_pkg::ST_DELAY) |->
         $past(cnt_ff) == CNT_W'(PIN_CYC - 1);
   endproperty
   a_pin_delay: assert property (p_pin_delay)
      else $error("release came before the full pin reset delay");

   property p_shared_off;
      (pin_func_ff == mrs_pkg::PIN_FUNC_RESET) |-> o_shared_fn_disable;
   endproperty
   a_shared_off: assert property (p_shared_off)
      else $error("shared pin function left enabled");

   property p_ctrl_fault;
      s_soft_fire |=> s_reset_taken ##0 flags_ff[mrs_pkg::FLAG_CTRL_CODE] &&
         (pin_func_ff == mrs_pkg::PIN_FUNC_POR);
   endproperty
   a_ctrl_fault: assert property (p_ctrl_fault)
      else $error("control code fault did not reset and flag");

   property p_flag_sticky;
      flags_ff[mrs_pkg::FLAG_CTRL_CODE] && !(wr_flags && !i_wdata[3]) |=>
         flags_ff[mrs_pkg::FLAG_CTRL_CODE];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("control code flag dropped without a clear");

   property p_read_high_zero;
      i_rd && (i_addr == mrs_pkg::ADDR_FLAGS) |=> o_rdata[7:4] == 4'h0 &&
         o_rdata[3:0] == $past(flags_ff);
   endproperty
   a_read_high_zero: assert property (p_read_high_zero)
      else $error("flag register read wrong");

   property p_lv_filter;
      $rose(lv_hit) |-> $past(lv_low, 1) && $past(lv_low, 2) && $past(lv_low, 3);
   endproperty
   a_lv_filter: assert property (p_lv_filter)
      else $error("undervolt reset on a short dip");

   property p_lv_reset;
      lv_hit |=> o_core_reset && flags_ff[mrs_pkg::FLAG_UNDERVOLT];
   endproperty
   a_lv_reset: assert property (p_lv_reset)
      else $error("undervolt did not reset and flag");

   property p_thr_restore;
      fire && thr_bad |=> (thr_ff == mrs_pkg::THR_POR) && flags_ff[mrs_pkg::FLAG_THR_CODE];
   endproperty
   a_thr_restore: assert property (p_thr_restore)
      else $error("threshold fault did not restore the register");

   property p_power_down;
      i_power_down |=> !o_undervolt_en ##1 !lv_hit;
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("undervolt reset active in power-down");

   property p_wdt_reset;
      i_wdt_overflow && !hard_evt |=> o_core_reset;
   endproperty
   a_wdt_reset: assert property (p_wdt_reset)
      else $error("watchdog overflow did not reset");

   sequence s_soft_enter;
      (state_ff == mrs_pkg::ST_RUN) && soft_bad && !hard_evt && !i_wdt_overflow;
   endsequence

   property p_soft_delay;
      s_soft_enter |=> (state_ff == mrs_pkg::ST_SOFT) && !o_core_reset;
   endproperty
   a_soft_delay: assert property (p_soft_delay)
      else $error("code fault reset without the soft delay");

   property p_run_quiet;
      (state_ff == mrs_pkg::ST_RUN) && !hard_evt && !i_wdt_overflow |=> !o_core_reset;
   endproperty
   a_run_quiet: assert property (p_run_quiet)
      else $error("reset without a reset source");

   property p_thr_keep;
      lv_hit && !wr_thr |=> $stable(thr_ff);
   endproperty
   a_thr_keep: assert property (p_thr_keep)
      else $error("undervolt reset changed the threshold register");

   property p_uv_sticky;
      flags_ff[mrs_pkg::FLAG_UNDERVOLT] && !(wr_flags && !i_wdata[mrs_pkg::FLAG_UNDERVOLT])
         |=> flags_ff[mrs_pkg::FLAG_UNDERVOLT];
   endproperty
   a_uv_sticky: assert property (p_uv_sticky)
      else $error("undervolt flag dropped without a clear");
endmodule : mrs_reset_ctrl

// [tb/mrs_far_side_model.sv]
// Far side model: reset pin driver with pull-up and supply monitor
`timescale 1ns/100ps
module mrs_far_side_model (
   input wire logic i_pull_low,
   input wire logic [1:0] i_supply_mode,
   output logic o_pin_n,
   output logic [3:0] o_below,
   output logic o_above_floor
);
   // ----------------------------------------------------------------
   // Pin and supply
   // ----------------------------------------------------------------
   // A released pin returns high through the pull-up of the RC network
   assign o_pin_n = !i_pull_low;
   // Below the lowest level means below every higher level as well
   // Mode 3 sits between the two middle levels: below the upper two only
   assign o_below = (i_supply_mode == 2'd3) ? 4'hc : (i_supply_mode != 2'd0) ? 4'hf : 4'h0;
   // Mode 2 is a supply under the floor where the monitor stops working
   assign o_above_floor = (i_supply_mode != 2'd2);
endmodule : mrs_far_side_model

// [tb/tb_mrs_reset_ctrl.sv]
// Testbench for the reset source controller
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
   $display("ERROR %0t mismatch %h vs %h", $time, a, b); end end
module tb_mrs_reset_ctrl;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   // Short counts keep the run brief; expectations derive from these
   localparam int SC = 4;
   localparam int PC = 8;
   localparam int FC = 6;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_power_down = 1'b0;
   logic i_wdt_overflow = 1'b0;
   logic i_wdt_code_fault = 1'b0;
   logic pull_low = 1'b0;
   logic [1:0] supply_mode = 2'd0;
   logic [7:0] o_rdata;
   logic pin_n;
   logic [3:0] below;
   logic above_floor;
   logic o_core_reset;
   logic o_port_preset;
   logic o_shared_fn_disable;
   logic o_undervolt_en;
   int fail_count = 0;
   int comparisons = 0;
   int n;
   logic [7:0] v;
   logic [7:0] codes [4];
   always #20 i_mclk = !i_mclk;
   mrs_reset_ctrl #(.SOFT_CYC(SC), .PIN_CYC(PC), .FILT_CYC(FC)) mrs_reset_ctrl_inst (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_reset_pin_n(pin_n),
      .i_supply_below(below), .i_supply_above_floor(above_floor),
      .i_power_down(i_power_down), .i_wdt_overflow(i_wdt_overflow),
      .i_wdt_code_fault(i_wdt_code_fault), .o_core_reset(o_core_reset),
      .o_port_preset(o_port_preset), .o_shared_fn_disable(o_shared_fn_disable),
      .o_undervolt_en(o_undervolt_en));
   mrs_far_side_model mrs_far_side_model_inst (
      .i_pull_low(pull_low), .i_supply_mode(supply_mode), .o_pin_n(pin_n),
      .o_below(below), .o_above_floor(above_floor));
   // ----------------------------------------------------------------
   // Bus and timing helpers
   // ----------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
   endtask : rd
   task automatic cycles(input int c);
      repeat (c) @(posedge i_mclk);
      #1;
   endtask : cycles
   // Counts edges until the core reset reaches a level, bounded
   task automatic wait_lvl(input logic lvl);
      #1;
      n = 0;
      while (o_core_reset !== lvl && n < 60) begin
         @(posedge i_mclk);
         #1;
         n++;
      end
   endtask : wait_lvl
   task automatic test_done;
      if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_por;
      `CHK(o_core_reset, 1'b1)
      `CHK(o_port_preset, 1'b1)
      @(posedge i_mclk);
      i_resetn <= 1'b1;
      wait_lvl(1'b0);
      `CHK(n >= PC && n <= PC + 2, 1'b1)
      `CHK(o_port_preset, 1'b0)
      rd(mrs_pkg::ADDR_PIN_FUNC);
      `CHK(v, 8'h55)
      rd(mrs_pkg::ADDR_THRESH);
      `CHK(v, 8'h55)
      rd(mrs_pkg::ADDR_FLAGS);
      `CHK(v, 8'h00)
      rd(4'h2);
      `CHK(v, 8'h00)
      rd(mrs_pkg::ADDR_STATUS);
      `CHK(v, 8'h01)
   endtask : t_por
   task automatic t_pin;
      // Plain I/O function: a low pin must not reset
      @(posedge i_mclk);
      pull_low <= 1'b1;
      cycles(6);
      `CHK(o_core_reset, 1'b0)
      pull_low <= 1'b0;
      wr(mrs_pkg::ADDR_PIN_FUNC, mrs_pkg::PIN_FUNC_RESET);
      cycles(1);
      `CHK(o_shared_fn_disable, 1'b1)
      @(posedge i_mclk);
      pull_low <= 1'b1;
      wait_lvl(1'b1);
      `CHK(n <= 3, 1'b1)
      cycles(12);
      `CHK(o_core_reset, 1'b1)
      pull_low <= 1'b0;
      wait_lvl(1'b0);
      `CHK(n >= PC && n <= PC + 3, 1'b1)
      wr(mrs_pkg::ADDR_PIN_FUNC, mrs_pkg::PIN_FUNC_IO);
      cycles(1);
      `CHK(o_shared_fn_disable, 1'b0)
   endtask : t_pin
   task automatic t_bad_pin;
      wr(mrs_pkg::ADDR_PIN_FUNC, 8'h12);
      wait_lvl(1'b1);
      `CHK(n >= SC && n <= SC + 3, 1'b1)
      wait_lvl(1'b0);
      rd(mrs_pkg::ADDR_FLAGS);
      `CHK(v, 8'h08)
      rd(mrs_pkg::ADDR_PIN_FUNC);
      `CHK(v, 8'h55)
      wr(mrs_pkg::ADDR_FLAGS, 8'hff);
      rd(mrs_pkg::ADDR_FLAGS);
      `CHK(v, 8'h08)
      wr(mrs_pkg::ADDR_FLAGS, 8'h00);
      rd(mrs_pkg::ADDR_FLAGS);
      `CHK(v, 8'h00)
   endtask : t_bad_pin
   task automatic t_thr;
      codes = '{mrs_pkg::THR_CODE_1, mrs_pkg::THR_CODE_2, mrs_pkg::THR_CODE_3,
         mrs_pkg::THR_CODE_0};
      for (int i = 0; i < 4; i++) begin
         wr(mrs_pkg::ADDR_THRESH, codes[i]);
         rd(mrs_pkg::ADDR_THRESH);
         `CHK(v, codes[i])
         `CHK(o_core_reset, 1'b0)
      end
      wr(mrs_pkg::ADDR_THRESH, 8'h00);
      wait_lvl(1'b1);
      `CHK(n >= SC && n <= SC + 3, 1'b1)
      wait_lvl(1'b0);
      rd(mrs_pkg::ADDR_FLAGS);
      `CHK(v, 8'h02)
      rd(mrs_pkg::ADDR_THRESH);
      `CHK(v, 8'h55)
      wr(mrs_pkg::ADDR_FLAGS, 8'h00);
   endtask : t_thr
   task automatic t_uv;
      wr(mrs_pkg::ADDR_THRESH, mrs_pkg::THR_CODE_1);
      @(posedge i_mclk);
      supply_mode <= 2'd1;
      repeat (FC - 2) @(posedge i_mclk);
      supply_mode <= 2'd0;
      cycles(10);
      `CHK(o_core_reset, 1'b0)
      supply_mode <= 2'd1;
      wait_lvl(1'b1);
      `CHK(n >= FC && n <= FC + 4, 1'b1)
      rd(mrs_pkg::ADDR_FLAGS);
      `CHK(v, 8'h04)
      supply_mode <= 2'd0;
      wait_lvl(1'b0);
      rd(mrs_pkg::ADDR_THRESH);
      `CHK(v, mrs_pkg::THR_CODE_1)
      wr(mrs_pkg::ADDR_FLAGS, 8'h00);
      rd(mrs_pkg::ADDR_FLAGS);
      `CHK(v, 8'h00)
      supply_mode <= 2'd2;
      cycles(FC + 6);
      `CHK(o_core_reset, 1'b0)
      // Supply under the upper levels only: the selected lower level keeps quiet
      supply_mode <= 2'd3;
      cycles(FC + 6);
      `CHK(o_core_reset, 1'b0)
      supply_mode <= 2'd0;
      i_power_down <= 1'b1;
      cycles(2);
      `CHK(o_undervolt_en, 1'b0)
      supply_mode <= 2'd1;
      cycles(FC + 6);
      `CHK(o_core_reset, 1'b0)
      supply_mode <= 2'd0;
      cycles(1);
      i_power_down <= 1'b0;
      cycles(2);
      `CHK(o_undervolt_en, 1'b1)
   endtask : t_uv
   task automatic t_wdt;
      @(posedge i_mclk);
      i_wdt_overflow <= 1'b1;
      @(posedge i_mclk);
      i_wdt_overflow <= 1'b0;
      wait_lvl(1'b1);
      `CHK(n <= 3, 1'b1)
      wait_lvl(1'b0);
      i_wdt_code_fault <= 1'b1;
      wait_lvl(1'b1);
      `CHK(n >= SC && n <= SC + 3, 1'b1)
      i_wdt_code_fault <= 1'b0;
      wait_lvl(1'b0);
      rd(mrs_pkg::ADDR_FLAGS);
      `CHK(v, 8'h01)
   endtask : t_wdt
   initial begin
      repeat (7) @(posedge i_mclk);
      #1;
      t_por();
      t_pin();
      t_bad_pin();
      t_thr();
      t_uv();
      t_wdt();
      test_done();
   end
   // Whole run is well under a thousand cycles
   initial begin
      #200000;
      fail_count++;
      test_done();
   end
endmodule : tb_mrs_reset_ctrl
